// File: rtl/asc_ctrl.sv
// converter sequencer top: AHB-Lite registers, scan, oversample, watchdog
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module asc_ctrl
  import asc_pkg::*;
(
  input  wire logic                 hclk,       // clock 125 MHz
  input  wire logic                 hresetn,    // async reset, low
  input  wire logic                 hsel,       // slave select
  input  wire logic [11:0]          haddr,      // byte address
  input  wire logic [1:0]           htrans,     // transfer type
  input  wire logic                 hwrite,     // write access
  input  wire logic [2:0]           hsize,      // transfer size
  input  wire logic [31:0]          hwdata,     // write data
  input  wire logic                 hready,     // bus ready in
  output logic                      hreadyout,  // always ready
  output logic                      hresp,      // always okay
  output logic [31:0]               hrdata,     // read data
  input  wire logic [ASC_NTRIG-1:0] tim_trig,   // timer trigger pins
  input  wire logic [ASC_RESW-1:0]  comp_in,    // analog comparator word
  input  wire logic                 dma_ack,    // dma took data
  output logic                      dma_req,    // dma request level
  output logic                      core_pwr,   // analog core power on
  output logic [ASC_CHW-1:0]        ch_mux,     // input channel select
  output logic                      irq         // interrupt level
);
  logic [31:0]            cfg_r;
  logic [ASC_NCH-1:0]     chsel_r;
  logic [ASC_NCH-1:0]     wdch_r;
  logic [31:0]            thr_r;
  logic [ASC_OUTW-1:0]    data_r;
  logic [ASC_NSTAT-1:0]   stat_r;
  logic [ASC_NSTAT-1:0]   mask_r;
  logic                   ph_wr_r;
  logic                   ph_rd_r;
  logic [11:0]            ph_a_r;
  logic [ASC_NTRIG-1:0]   trg_s1_r;
  logic [ASC_NTRIG-1:0]   trg_s2_r;
  logic                   trg_d_r;
  asc_state_e             st_r;
  logic [3:0]             cnt_r;
  logic [ASC_CHW-1:0]     ch_r;
  logic [8:0]             ovs_r;
  logic [ASC_ACCW-1:0]    acc_r;
  logic                   sar_go_r;
  logic                   sar_done;
  logic [ASC_RESW-1:0]    sar_res;
  logic                   start_sw;
  logic                   trig_ev;
  logic                   res_ev;
  logic [ASC_OUTW-1:0]    res_val;
  logic                   last_ch;
  logic                   wd_hit;
  logic                   data_rd;
  logic [ASC_NSTAT-1:0]   stat_set;

  function automatic logic [ASC_CHW-1:0] next_sel(
    input logic [ASC_NCH-1:0] sel, input logic [ASC_CHW-1:0] from);
    logic [ASC_CHW-1:0] n;
    n = from;
    for (int i = ASC_NCH - 1; i >= 0; i--)
      if (sel[i] && (ASC_CHW'(i) > from))
        n = ASC_CHW'(i);
    return n;
  endfunction : next_sel

  function automatic logic [ASC_CHW-1:0] first_sel(
    input logic [ASC_NCH-1:0] sel);
    logic [ASC_CHW-1:0] n;
    n = '0;
    for (int i = ASC_NCH - 1; i >= 0; i--)
      if (sel[i])
        n = ASC_CHW'(i);
    return n;
  endfunction : first_sel

  // bus data phase
  wire logic addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_a_r  <= '0;
    end
    else if (hready)
    begin
      ph_wr_r <= addr_ok && hwrite;
      ph_rd_r <= addr_ok && !hwrite;
      ph_a_r  <= haddr;
    end
  end

  wire logic wr_ctrl = ph_wr_r && (ph_a_r == ASC_A_CTRL);
  assign start_sw = wr_ctrl && hwdata[0];
  assign data_rd  = ph_rd_r && (ph_a_r == ASC_A_DATA);

  // readback captured in address phase so hrdata comes from a flop
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr == ASC_A_CTRL)
      rd_mux = {31'h0, st_r != ASC_IDLE};
    else if (haddr == ASC_A_CFG)
      rd_mux = cfg_r;
    else if (haddr == ASC_A_CHSEL)
      rd_mux = 32'(chsel_r);
    else if (haddr == ASC_A_WDCH)
      rd_mux = 32'(wdch_r);
    else if (haddr == ASC_A_THR)
      rd_mux = thr_r;
    else if (haddr == ASC_A_DATA)
      rd_mux = 32'(data_r);
    else if (haddr == ASC_A_STAT)
      rd_mux = 32'(stat_r);
    else if (haddr == ASC_A_MASK)
      rd_mux = 32'(mask_r);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_r   <= '0;
      chsel_r <= '0;
      wdch_r  <= '0;
      thr_r   <= '0;
      mask_r  <= '0;
    end
    else if (ph_wr_r)
    begin
      if (ph_a_r == ASC_A_CFG)
        cfg_r <= hwdata;
      else if (ph_a_r == ASC_A_CHSEL)
        chsel_r <= hwdata[ASC_NCH-1:0];
      else if (ph_a_r == ASC_A_WDCH)
        wdch_r <= hwdata[ASC_NCH-1:0];
      else if (ph_a_r == ASC_A_THR)
        thr_r <= hwdata;
      else if (ph_a_r == ASC_A_MASK)
        mask_r <= hwdata[ASC_NSTAT-1:0];
    end
  end

  // timer triggers synchronised, rising edge of selected line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trg_s1_r <= '0;
      trg_s2_r <= '0;
      trg_d_r  <= 1'b0;
    end
    else
    begin
      trg_s1_r <= tim_trig;
      trg_s2_r <= trg_s1_r;
      trg_d_r  <= trg_s2_r[cfg_r[ASC_F_TRIGSEL +: 2]];
    end
  end
  assign trig_ev = cfg_r[ASC_F_TRIGEN] && !trg_d_r &&
                   trg_s2_r[cfg_r[ASC_F_TRIGSEL +: 2]];

  // sequencer
  wire logic [3:0] ovs_log = (cfg_r[ASC_F_OVSLOG +: 4] > ASC_MAX_OVS_LOG) ?
                             ASC_MAX_OVS_LOG : cfg_r[ASC_F_OVSLOG +: 4];
  wire logic [8:0] ovs_n = cfg_r[ASC_F_OVSEN] ? (9'h001 << ovs_log) : 9'h001;
  wire logic [ASC_ACCW-1:0] acc_sum = acc_r + ASC_ACCW'(sar_res);
  // 12 bits plus log2 samples, scaled to 16 bits
  wire logic [ASC_ACCW-1:0] acc_scl = (ovs_log > 4'h4) ?
    (acc_sum >> (ovs_log - 4'h4)) : (acc_sum << (4'h4 - ovs_log));
  assign res_val = cfg_r[ASC_F_OVSEN] ? acc_scl[ASC_OUTW-1:0] :
                   ASC_OUTW'(sar_res);
  assign res_ev  = sar_done && (ovs_r == ovs_n - 9'h001);
  assign last_ch = next_sel(chsel_r, ch_r) == ch_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r     <= ASC_IDLE;
      cnt_r    <= '0;
      ch_r     <= '0;
      ovs_r    <= '0;
      acc_r    <= '0;
      sar_go_r <= 1'b0;
    end
    else
    begin
      sar_go_r <= 1'b0;
      case (st_r)
        ASC_IDLE:
          if ((start_sw || trig_ev) && chsel_r != '0)
          begin
            ch_r  <= first_sel(chsel_r);
            ovs_r <= '0;
            acc_r <= '0;
            cnt_r <= '0;
            st_r  <= ASC_PWRUP;
          end
        ASC_PWRUP:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r >= ASC_PWRUP_CYC || !cfg_r[ASC_F_AUTOOFF])
          begin
            cnt_r <= '0;
            st_r  <= ASC_SAMPLE;
          end
        end
        ASC_SAMPLE:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r >= (ASC_FAST_MASK[ch_r] ? ASC_SMP_FAST : ASC_SMP_STD))
          begin
            sar_go_r <= 1'b1;
            st_r     <= ASC_CONV;
          end
        end
        ASC_CONV:
          if (sar_done)
          begin
            acc_r <= acc_sum;
            ovs_r <= ovs_r + 9'h001;
            cnt_r <= '0;
            st_r  <= ASC_SAMPLE;
            if (res_ev)
              st_r <= ASC_NEXT;
          end
        ASC_NEXT:
        begin
          ovs_r <= '0;
          acc_r <= '0;
          cnt_r <= '0;
          if (!last_ch)
          begin
            ch_r <= next_sel(chsel_r, ch_r);
            st_r <= ASC_SAMPLE;
          end
          else if (cfg_r[ASC_F_CONT])
          begin
            ch_r <= first_sel(chsel_r);
            st_r <= ASC_SAMPLE;
          end
          else
            st_r <= ASC_IDLE;
        end
        default:
          st_r <= ASC_IDLE;
      endcase
    end
  end

  asc_sar_core u_sar (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (sar_go_r),
    .comp_in (comp_in),
    .done    (sar_done),
    .result  (sar_res)
  );

  // watchdog: single channel or per-channel subset mask
  wire logic wd_watch = cfg_r[ASC_F_WDEN] && (cfg_r[ASC_F_WDSINGLE] ?
    (ch_r == cfg_r[ASC_F_WDCH +: ASC_CHW]) : wdch_r[ch_r]);
  assign wd_hit = res_ev && wd_watch && ((res_val < thr_r[15:0]) ||
                  (res_val > thr_r[31:16]));

  assign stat_set[ASC_S_EOC] = res_ev;
  assign stat_set[ASC_S_WD]  = wd_hit;
  assign stat_set[ASC_S_EOS] = res_ev && last_ch;
  assign stat_set[ASC_S_OVR] = res_ev && stat_r[ASC_S_EOC];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_r <= '0;
      stat_r <= '0;
    end
    else
    begin
      if (res_ev)
        data_r <= res_val;
      for (int i = 0; i < ASC_NSTAT; i++)
        if (stat_set[i])
          stat_r[i] <= 1'b1;
        else if ((ph_wr_r && ph_a_r == ASC_A_STAT && hwdata[i]) ||
                 (i == ASC_S_EOC && (data_rd || (dma_req && dma_ack))))
          stat_r[i] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq      <= 1'b0;
      dma_req  <= 1'b0;
      core_pwr <= 1'b0;
      ch_mux   <= '0;
    end
    else
    begin
      irq <= |(stat_r & mask_r);
      if (res_ev && cfg_r[ASC_F_DMAEN])
        dma_req <= 1'b1;
      else if (dma_ack || data_rd)
        dma_req <= 1'b0;
      core_pwr <= !cfg_r[ASC_F_AUTOOFF] || (st_r != ASC_IDLE);
      ch_mux   <= ch_r;
    end
  end
  // sequencing counts only hclk; no tie to processor speed
endmodule : asc_ctrl

// File: pkg/asc_pkg.sv
// package: register map, fields and constants of the converter sequencer
package asc_pkg;
  localparam int ASC_NCH      = 19;
  localparam int ASC_CHW      = 5;
  localparam int ASC_RESW     = 12;
  localparam int ASC_OUTW     = 16;
  localparam int ASC_ACCW     = 20;
  localparam int ASC_NTRIG    = 4;
  localparam logic [4:0] ASC_CH_BANDGAP = 5'h11;
  localparam logic [4:0] ASC_CH_TEMP    = 5'h12;
  localparam logic [ASC_NCH-1:0] ASC_FAST_MASK = 19'h00031;
  localparam logic [3:0] ASC_MAX_OVS_LOG = 4'h8;
  localparam logic [3:0] ASC_SMP_FAST   = 4'h2;
  localparam logic [3:0] ASC_SMP_STD    = 4'h6;
  localparam logic [3:0] ASC_PWRUP_CYC  = 4'h3;
  localparam logic [11:0] ASC_A_CTRL    = 12'h000;
  localparam logic [11:0] ASC_A_CFG     = 12'h004;
  localparam logic [11:0] ASC_A_CHSEL   = 12'h008;
  localparam logic [11:0] ASC_A_WDCH    = 12'h00c;
  localparam logic [11:0] ASC_A_THR     = 12'h010;
  localparam logic [11:0] ASC_A_DATA    = 12'h014;
  localparam logic [11:0] ASC_A_STAT    = 12'h018;
  localparam logic [11:0] ASC_A_MASK    = 12'h01c;
  localparam int ASC_F_CONT = 0;
  localparam int ASC_F_AUTOOFF = 1;
  localparam int ASC_F_DMAEN = 2;
  localparam int ASC_F_TRIGEN = 3;
  localparam int ASC_F_TRIGSEL = 4;
  localparam int ASC_F_OVSEN = 8;
  localparam int ASC_F_OVSLOG = 12;
  localparam int ASC_F_WDEN = 16;
  localparam int ASC_F_WDSINGLE = 17;
  localparam int ASC_F_WDCH = 20;
  localparam int ASC_S_EOC = 0;
  localparam int ASC_S_WD = 1;
  localparam int ASC_S_EOS = 2;
  localparam int ASC_S_OVR = 3;
  localparam int ASC_NSTAT = 4;
  typedef enum logic [2:0] {ASC_IDLE, ASC_PWRUP, ASC_SAMPLE, ASC_CONV,
                            ASC_NEXT} asc_state_e;
endpackage : asc_pkg

// File: rtl/asc_sar_core.sv
// digital model of the 12-bit successive-approximation cycle
`timescale 1ns/1ps
module asc_sar_core
  import asc_pkg::*;
(
  input  wire logic                hclk,      // system clock
  input  wire logic                hresetn,   // async reset, low
  input  wire logic                start,     // begin conversion
  input  wire logic [ASC_RESW-1:0] comp_in,   // comparator level word
  output logic                     done,      // one-cycle result strobe
  output logic [ASC_RESW-1:0]      result     // converted code
);
  logic [ASC_RESW-1:0] bit_r;
  logic [ASC_RESW-1:0] acc_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bit_r  <= '0;
      acc_r  <= '0;
      done   <= 1'b0;
      result <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        bit_r <= {1'b1, {(ASC_RESW-1){1'b0}}};
        acc_r <= '0;
      end
      else if (bit_r != '0)
      begin
        // keep trial bit where comparator says input is above
        if (comp_in >= (acc_r | bit_r))
          acc_r <= acc_r | bit_r;
        bit_r <= bit_r >> 1;
        if (bit_r[0])
        begin
          done   <= 1'b1;
          result <= (comp_in >= (acc_r | bit_r)) ? (acc_r | bit_r) : acc_r;
        end
      end
    end
  end
endmodule : asc_sar_core

// File: verif/asc_ctrl_monitor.sv
// checker: bus and converter port relations of the sequencer
`timescale 1ns/1ps
module asc_ctrl_chk
  import asc_pkg::*;
(
  input wire logic               hclk,      // clock
  input wire logic               hresetn,   // reset, low
  input wire logic               hsel,      // select
  input wire logic [11:0]        haddr,     // address
  input wire logic [1:0]         htrans,    // transfer
  input wire logic               hwrite,    // write
  input wire logic               hready,    // ready in
  input wire logic               hreadyout, // ready out
  input wire logic               hresp,     // response
  input wire logic [31:0]        hrdata,    // read data
  input wire logic               dma_ack,   // dma took data
  input wire logic               dma_req,   // result waiting
  input wire logic               core_pwr,  // core power
  input wire logic [ASC_CHW-1:0] ch_mux     // channel
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic bus;
  assign bus = hsel && hready && htrans[1];
  sequence s_rd(a);
    bus && !hwrite && haddr == a;
  endsequence
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_mux;
    ch_mux < ASC_NCH;
  endproperty
  a_mux: assert property (p_mux) else $error("bad channel");
  property p_unmapped;
    bus && !hwrite && haddr > 12'h01c |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_ctrl;
    s_rd(ASC_A_CTRL) |=> hrdata[31:1] == 31'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control bits");
  property p_data;
    s_rd(ASC_A_DATA) |=> hrdata[31:16] == 16'h0;
  endproperty
  a_data: assert property (p_data) else $error("result too wide");
  property p_stat;
    s_rd(ASC_A_STAT) |=> hrdata[31:ASC_NSTAT] == '0;
  endproperty
  a_stat: assert property (p_stat) else $error("status bits");
  property p_pwr;
    $rose(core_pwr) |-> core_pwr [*8];
  endproperty
  a_pwr: assert property (p_pwr) else $error("power too short");
  property p_req;
    dma_req && !dma_ack && !bus && !$past(bus) |=> dma_req;
  endproperty
  a_req: assert property (p_req) else $error("request lost");
endmodule : asc_ctrl_chk

bind asc_ctrl asc_ctrl_chk asc_ctrl_chk_inst (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .dma_ack, .dma_req, .core_pwr, .ch_mux);

// File: verif/asc_far_model.sv
// far side: analog level per channel and a dma controller
`timescale 1ns/1ps
module asc_far_model
  import asc_pkg::*;
(
  input wire logic                hclk,     // clock
  input wire logic                hresetn,  // reset, low
  input wire logic                core_pwr, // core power
  input wire logic [ASC_CHW-1:0]  ch_mux,   // channel
  input wire logic                dma_req,  // result waiting
  input wire logic [3:0]          ack_wait, // ack delay, f never
  output logic [ASC_RESW-1:0]     comp_in,  // level word
  output logic                    dma_ack,  // took data
  output logic [7:0]              ack_cnt   // words taken
);
  logic [3:0] wait_r;
  // unpowered core gives a toggling word, never a held value
  always_ff @(posedge hclk)
    if (core_pwr)
      comp_in <= {3'h5, ch_mux, 4'h3};
    else
      comp_in <= ~comp_in;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dma_ack <= 1'b0;
      wait_r  <= 4'h0;
      ack_cnt <= 8'h00;
    end
    else if (dma_ack || !dma_req)
    begin
      dma_ack <= 1'b0;
      wait_r  <= 4'h0;
    end
    else if (ack_wait != 4'hf && wait_r == ack_wait)
    begin
      dma_ack <= 1'b1;
      ack_cnt <= ack_cnt + 8'h01;
    end
    else
      wait_r <= wait_r + 4'h1;
endmodule : asc_far_model

// File: verif/test_asc_ctrl.sv
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module test_asc_ctrl
  import asc_pkg::*;
;
  logic                hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic                hwrite = 1'b0, hready, hreadyout, hresp;
  logic                dma_ack, dma_req, core_pwr, irq;
  logic [11:0]         haddr = 12'h000;
  logic [1:0]          htrans = 2'h0;
  logic [31:0]         hwdata = 32'h0, hrdata, q;
  logic [3:0]          tim_trig = 4'h0, ack_wait = 4'hf;
  logic [ASC_RESW-1:0] comp_in;
  logic [ASC_CHW-1:0]  ch_mux;
  logic [7:0]          ack_cnt, base;
  int                  fails = 0, checks = 0, cyc = 0;
  int                  pwr_n = 0, p_std = 0, p0 = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  asc_ctrl asc_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .tim_trig, .comp_in, .dma_ack, .dma_req, .core_pwr, .ch_mux, .irq);
  asc_far_model asc_far_model_inst (.hclk, .hresetn, .core_pwr, .ch_mux,
    .dma_req, .ack_wait, .comp_in, .dma_ack, .ack_cnt);
  function automatic logic [31:0] lvl(input logic [4:0] c);
    return {20'h0, 3'h5, c, 4'h3};
  endfunction : lvl
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, ASC_A_STAT, 32'h0);
      n++;
    end
    while (q[b] !== 1'b1 && n < 200);
    chk({31'h0, q[b]}, 32'h1, "status flag missing");
  endtask : wait_st
  task automatic conv(input logic [31:0] cfg, sel);
    bus(1'b1, ASC_A_CFG, cfg);
    bus(1'b1, ASC_A_CHSEL, sel);
    bus(1'b1, ASC_A_STAT, 32'hf);
    bus(1'b1, ASC_A_CTRL, 32'h1);
  endtask : conv
  task automatic t_reset;
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, 12'(i * 4), 32'h0);
      chk(q, 32'h0, "reset value");
    end
    bus(1'b1, 12'h020, 32'hffffffff);
    bus(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task automatic t_single;
    conv(32'h2, 32'h40000);
    p0 = pwr_n;
    wait_st(ASC_S_EOC);
    bus(1'b0, ASC_A_DATA, 32'h0);
    chk(q, lvl(ASC_CH_TEMP), "temperature result");
    bus(1'b0, ASC_A_STAT, 32'h0);
    chk({31'h0, q[0]}, 32'h0, "end flag kept");
    chk({31'h0, core_pwr}, 32'h0, "core left on");
    p_std = pwr_n - p0;
    $display("test single done");
  endtask : t_single
  task automatic t_scan;
    ack_wait <= 4'h3;
    base = ack_cnt;
    conv(32'h6, 32'h20001);
    wait_st(ASC_S_EOS);
    bus(1'b0, ASC_A_DATA, 32'h0);
    chk(q, lvl(ASC_CH_BANDGAP), "last scan result");
    for (int n = 0; n < 50 && dma_req !== 1'b0; n++) @(posedge hclk);
    chk({31'h0, dma_req}, 32'h0, "request left high");
    chk({24'h0, ack_cnt - base}, 32'h2, "dma words");
    $display("test scan done");
  endtask : t_scan
  task automatic t_wdog;
    bus(1'b1, ASC_A_THR, 32'h01000000);
    bus(1'b1, ASC_A_MASK, 32'h2);
    conv(32'h01230002, 32'h40000);
    wait_st(ASC_S_EOC);
    chk({31'h0, q[1]}, 32'h1, "watchdog flag");
    chk({31'h0, irq}, 32'h1, "irq missing");
    bus(1'b1, ASC_A_MASK, 32'h0);
    bus(1'b0, ASC_A_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0, "masked irq");
    bus(1'b1, ASC_A_MASK, 32'h2);
    bus(1'b1, ASC_A_STAT, 32'h2);
    bus(1'b0, ASC_A_STAT, 32'h0);
    chk({31'h0, q[1] | irq}, 32'h0, "flag not cleared");
    conv(32'h01130002, 32'h40000);
    wait_st(ASC_S_EOC);
    chk({31'h0, q[1]}, 32'h0, "unwatched channel");
    $display("test watchdog done");
  endtask : t_wdog
  task automatic t_trig;
    bus(1'b1, ASC_A_CFG, 32'h2a);
    bus(1'b1, ASC_A_CHSEL, 32'h20);
    bus(1'b1, ASC_A_STAT, 32'hf);
    tim_trig <= 4'h2;
    repeat (4) @(posedge hclk);
    tim_trig <= 4'h0;
    repeat (40) @(posedge hclk);
    bus(1'b0, ASC_A_STAT, 32'h0);
    chk(q, 32'h0, "wrong trigger started");
    p0 = pwr_n;
    tim_trig <= 4'h4;
    repeat (4) @(posedge hclk);
    tim_trig <= 4'h0;
    wait_st(ASC_S_EOC);
    bus(1'b0, ASC_A_DATA, 32'h0);
    chk(q, lvl(5'h05), "fast channel result");
    // powered time of a standard and a fast conversion differ by sampling
    chk(32'(p_std - (pwr_n - p0)), 32'(ASC_SMP_STD - ASC_SMP_FAST),
        "fast sampling time");
    $display("test trigger done");
  endtask : t_trig
  task automatic t_cont;
    bus(1'b1, ASC_A_THR, 32'h0b000a00);
    bus(1'b1, ASC_A_WDCH, 32'h10);
    conv(32'h00010003, 32'h20010);
    wait_st(ASC_S_OVR);
    chk({31'h0, q[1]}, 32'h0, "subset watch");
    bus(1'b1, ASC_A_STAT, 32'hf);
    wait_st(ASC_S_EOS);
    bus(1'b1, ASC_A_WDCH, 32'h20000);
    bus(1'b1, ASC_A_STAT, 32'hf);
    wait_st(ASC_S_WD);
    bus(1'b1, ASC_A_CFG, 32'h2);
    repeat (100) @(posedge hclk);
    bus(1'b0, ASC_A_CTRL, 32'h0);
    chk(q, 32'h0, "scan kept running");
    chk({31'h0, core_pwr}, 32'h0, "core on after scan");
    $display("test continuous done");
  endtask : t_cont
  task automatic t_ovs;
    conv(32'h00008102, 32'h40000);
    // 256 samples take far longer than the first check point
    repeat (4000) @(posedge hclk);
    bus(1'b0, ASC_A_STAT, 32'h0);
    chk({31'h0, q[0]}, 32'h0, "too few samples");
    repeat (1300) @(posedge hclk);
    wait_st(ASC_S_EOC);
    bus(1'b0, ASC_A_DATA, 32'h0);
    chk(q, lvl(ASC_CH_TEMP) << 4, "oversampled result");
    $display("test oversample done");
  endtask : t_ovs
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  always @(posedge hclk)
  begin
    cyc++;
    if (core_pwr === 1'b1)
      pwr_n++;
    if (cyc == 40000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_single();
    t_scan();
    t_wdog();
    t_trig();
    t_cont();
    t_ovs();
    results();
  end
endmodule : test_asc_ctrl
